// >>> hdl/tlo_defines.svh
`ifndef TLO_DEFINES_SVH
`define TLO_DEFINES_SVH
// Register byte offsets
`define TLO_REG_TRIG_CTRL   12'h000
`define TLO_REG_TRIG_COUNT  12'h004
`define TLO_REG_SW_TRIG     12'h008
`define TLO_REG_FAULT_CTRL  12'h00c
`define TLO_REG_A_LOWER     12'h010
`define TLO_REG_A_UPPER     12'h014
`define TLO_REG_A_HYST      12'h018
`define TLO_REG_B_LOWER     12'h01c
`define TLO_REG_B_UPPER     12'h020
`define TLO_REG_B_HYST      12'h024
`define TLO_REG_HOLD_MS     12'h028
`define TLO_REG_STATUS      12'h02c
`define TLO_REG_IRQ_STAT    12'h030
`define TLO_REG_IRQ_EN      12'h034
`define TLO_REG_IRQ_CLR     12'h038
// Limits in units of 0.1 mm
`define TLO_LIMIT_MAX       32'sd21470
`define TLO_LIMIT_MIN       -32'sd21470
`define TLO_COUNT_MAX       14'd16382
`define TLO_HOLD_MAX_MS     10'd1000
// Timing
`define TLO_CLK_MHZ         200
`define TLO_MS_NS           1000000
`define TLO_CLK_NS          5
`define TLO_CYC_PER_MS      (`TLO_MS_NS / `TLO_CLK_NS)
`endif

// >>> hdl/tlo_pkg.sv
package tlo_pkg;
  typedef enum logic [1:0] {TLO_SRC_NONE, TLO_SRC_MULTI, TLO_SRC_SYNC, TLO_SRC_SW} tlo_origin_t;
  typedef enum logic [1:0] {TLO_CMP_LOWER, TLO_CMP_UPPER, TLO_CMP_BOTH} tlo_cmp_t;
  typedef enum logic [1:0] {TLO_FSRC_INVALID_DISTANCE_SRC, TLO_FSRC_ARANGE, TLO_FSRC_LIMIT} tlo_fsrc_t;
  typedef enum logic [1:0] {TLO_DRV_SINK, TLO_DRV_SOURCE, TLO_DRV_PP, TLO_DRV_PPINV} tlo_drive_t;
endpackage

// >>> hdl/tlo_limit_chan.sv
`timescale 1ns/10ps
// One limit channel: compare, hysteresis, source select, minimum hold
module tlo_limit_chan
  import tlo_pkg::*;
#(
  parameter int HOLD_CYC_PER_MS = 200000
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Configuration
  input  wire tlo_pkg::tlo_cmp_t cmp_mode,
  input  wire tlo_pkg::tlo_fsrc_t fsrc,
  input  wire logic signed [31:0] lower,
  input  wire logic signed [31:0] upper,
  input  wire logic [31:0]       hyst,
  input  wire logic [9:0]        hold_ms,
  // Measurement
  input  wire logic signed [31:0] value,
  input  wire logic              invalid_distance_src_invalid,
  input  wire logic              out_of_range,
  // Result
  output logic                   fault
);
  logic        lim_state;
  logic [31:0] hold_cnt;
  logic        raw;
  logic        next_lim;
  logic signed [32:0] lo_rel;
  logic signed [32:0] hi_rel;
  logic        below;
  logic        above;
  logic        back_lo;
  logic        back_hi;

  // Violation and release points widened to avoid overflow
  assign lo_rel  = 33'(lower) + 33'(signed'({1'b0, hyst}));
  assign hi_rel  = 33'(upper) - 33'(signed'({1'b0, hyst}));
  assign below   = 33'(value) < 33'(lower);
  assign above   = 33'(value) > 33'(upper);
  assign back_lo = 33'(value) >= lo_rel;
  assign back_hi = 33'(value) <= hi_rel;

  // Set on violation, clear only past hysteresis
  always_comb begin
    next_lim = lim_state;
    case (cmp_mode)
      TLO_CMP_LOWER: next_lim = below | (lim_state & ~back_lo); // R8 R18
      TLO_CMP_UPPER: next_lim = above | (lim_state & ~back_hi); // R8 R18
      TLO_CMP_BOTH: next_lim = below | above | (lim_state & ~(back_lo & back_hi)); // R8 R18
      default: next_lim = 1'b0;
    endcase
  end

  // Error source selection
  assign raw = (fsrc == TLO_FSRC_INVALID_DISTANCE_SRC)   ? invalid_distance_src_invalid :   // R12
               (fsrc == TLO_FSRC_ARANGE) ? out_of_range :   // R13
               (fsrc == TLO_FSRC_LIMIT)  ? lim_state : 1'b0; // R14

  // Limit state and minimum hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_state <= 1'b0;
      hold_cnt  <= 32'h0;
      fault     <= 1'b0;
    end else begin
      lim_state <= next_lim;
      if (raw) begin
        fault    <= 1'b1;
        hold_cnt <= 32'(hold_ms) * 32'(HOLD_CYC_PER_MS); // R11
      end else if (hold_cnt != 32'h0) begin
        hold_cnt <= hold_cnt - 32'h1; // R11
      end else begin
        fault <= 1'b0;
      end
    end
  end

  a_hold_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (fault && !raw && hold_cnt != 32'h0) |=> fault) else $error("fault dropped during hold"); // R11
endmodule // tlo_limit_chan

// >>> hdl/tlo_sync3.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser; change accepted when stages two and three agree
module tlo_sync3 (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and result
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // Stage chain and agreement filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule // tlo_sync3

// >>> hdl/tlo_trigger_limit.sv
`timescale 1ns/10ps
`include "tlo_defines.svh"
// Operation
// R1 - Trigger gates acquisition or only output
// R2 - Emit exactly count values per event
// R3 - Unlimited count runs on after first event
// R4 - Polarity picks rising/high or falling/low
// R5 - Edge or level detection mode
// R6 - Origin none, multifunction, sync or software
// R7 - Software command triggers only in software origin
// R8 - Compare lower, upper or both per channel
// R9 - Each channel holds lower and upper limits
// R10 - Each channel applies a programmable hysteresis
// R11 - Fault held at least minimum hold time
// R12 - Invalid-distance source flags no valid distance
// R13 - Analog-range source flags out-of-range distance
// R14 - Limit source follows limit comparison
// R15 - Each channel compares a selected signal
// R16 - Drive style sink, source, push-pull, inverted
// R17 - Settings read back their current value
// R18 - Limit error clears past hysteresis only
// R19 - Level mode gates while input active
module tlo_trigger_limit
  import tlo_pkg::*;
#(
  parameter int HOLD_CYC_PER_MS = `TLO_CYC_PER_MS
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger pins
  input  wire logic        multifunction_input,
  input  wire logic        sync_line_input,
  // Measurement stream
  input  wire logic        meas_strobe,
  input  wire logic signed [31:0] meas_sig0,
  input  wire logic signed [31:0] meas_sig1,
  input  wire logic        invalid_distance_src_invalid,
  input  wire logic        out_of_range,
  // Gating outputs
  output logic             acquire_en,
  output logic             emit_strobe,
  // Fault outputs, tri-state pins (value and enable)
  output logic             fault_output_a_o,
  output logic             fault_output_a_oe,
  output logic             fault_output_b_o,
  output logic             fault_output_b_oe,
  // Interrupt
  output logic             irq
);
  // Configuration state
  logic             trigger_target_select;  // 1: gate emission only
  logic             unlimited_count;
  logic             trigger_polarity;       // 1: high/rising
  logic             trigger_detect_mode;    // 1: level
  tlo_origin_t      trigger_origin_select;
  logic [13:0]      values_per_event;
  tlo_cmp_t         limit_a_compare_mode;
  tlo_cmp_t         limit_b_compare_mode;
  tlo_fsrc_t        fsrc_a;
  tlo_fsrc_t        fsrc_b;
  logic             limit_a_signal_select;
  logic             limit_b_signal_select;
  tlo_drive_t       fault_a_drive_style;
  tlo_drive_t       fault_b_drive_style;
  logic signed [31:0] a_lower;
  logic signed [31:0] a_upper;
  logic [31:0]      limit_a_hysteresis;
  logic signed [31:0] b_lower;
  logic signed [31:0] b_upper;
  logic [31:0]      limit_b_hysteresis;
  logic [9:0]       fault_min_hold;
  // Trigger and counting state
  logic             sw_pulse;
  logic             trig_prev;
  logic [13:0]      remaining;
  logic             running;
  logic [3:0]       irq_stat;
  logic [3:0]       irq_en;
  logic             fault_a_d;
  logic             fault_b_d;

  // Synchronised pins
  wire multi_lvl;
  wire sync_lvl;
  tlo_sync3 u_sync_multi (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (multifunction_input),
    .level   (multi_lvl)
  );
  tlo_sync3 u_sync_line (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (sync_line_input),
    .level   (sync_lvl)
  );

  // APB decode
  wire        wr_en  = psel & penable & pwrite;
  wire        rd_en  = psel & penable & ~pwrite;
  wire        mapped = (paddr[1:0] == 2'b00) && (paddr <= `TLO_REG_IRQ_CLR);
  wire        wr_ok  = wr_en & mapped;
  wire        sw_cmd = wr_ok && paddr == `TLO_REG_SW_TRIG && pwdata[0];

  // Limit range clamp for signed tenths of a millimetre
  function automatic logic signed [31:0] clamp_lim(input logic signed [31:0] v);
    if (v > `TLO_LIMIT_MAX)
      clamp_lim = `TLO_LIMIT_MAX;
    else if (v < `TLO_LIMIT_MIN)
      clamp_lim = `TLO_LIMIT_MIN;
    else
      clamp_lim = v;
  endfunction

  // Hysteresis clamp 0 to the upper limit
  function automatic logic [31:0] clamp_hys(input logic [31:0] v);
    clamp_hys = (v[31] || v > 32'(`TLO_LIMIT_MAX)) ? 32'(`TLO_LIMIT_MAX) : v;
  endfunction

  // Drive style to pin value and enable
  function automatic logic [1:0] drive(input tlo_drive_t s, input logic f);
    case (s)
      TLO_DRV_SINK:   drive = {1'b0, f};   // Pulls low when asserted
      TLO_DRV_SOURCE: drive = {1'b1, f};   // Drives high when asserted
      TLO_DRV_PP:     drive = {f, 1'b1};
      TLO_DRV_PPINV:  drive = {~f, 1'b1};  // Inverted sense
      default:        drive = 2'b00;
    endcase
  endfunction

  // Trigger source selection and polarity
  wire src_lvl = (trigger_origin_select == TLO_SRC_MULTI) ? multi_lvl : // R6
                 (trigger_origin_select == TLO_SRC_SYNC) ? sync_lvl : 1'b0; // R6
  wire act_lvl = trigger_polarity ? src_lvl : ~src_lvl; // R4
  wire pin_sel = (trigger_origin_select == TLO_SRC_MULTI) || (trigger_origin_select == TLO_SRC_SYNC);
  wire edge_ev = pin_sel & act_lvl & ~trig_prev;        // R5
  wire event_p = (pin_sel & ~trigger_detect_mode & edge_ev) | sw_pulse; // R5 R7
  wire level_on = pin_sel & trigger_detect_mode & act_lvl; // R19

  // Gate: level mode, unlimited run, or counted values pending
  wire gate = level_on | running | (remaining != 14'h0);
  wire last_val = meas_strobe & ~level_on & ~running & (remaining != 14'h0);

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_target_select <= 1'b0;
      unlimited_count       <= 1'b0;
      trigger_polarity      <= 1'b1;
      trigger_detect_mode   <= 1'b0;
      trigger_origin_select <= TLO_SRC_NONE;
      values_per_event      <= 14'h1;
      limit_a_compare_mode  <= TLO_CMP_BOTH;
      limit_b_compare_mode  <= TLO_CMP_BOTH;
      fsrc_a                <= TLO_FSRC_INVALID_DISTANCE_SRC;
      fsrc_b                <= TLO_FSRC_INVALID_DISTANCE_SRC;
      limit_a_signal_select <= 1'b0;
      limit_b_signal_select <= 1'b0;
      fault_a_drive_style   <= TLO_DRV_PP;
      fault_b_drive_style   <= TLO_DRV_PP;
      a_lower               <= 32'h0;
      a_upper               <= 32'h0;
      limit_a_hysteresis    <= 32'h0;
      b_lower               <= 32'h0;
      b_upper               <= 32'h0;
      limit_b_hysteresis    <= 32'h0;
      fault_min_hold        <= 10'h0;
      irq_en                <= 4'h0;
    end else if (wr_ok) begin
      case (paddr)
        `TLO_REG_TRIG_CTRL: begin
          trigger_target_select <= pwdata[0]; // R1
          trigger_polarity      <= pwdata[1]; // R4
          trigger_detect_mode   <= pwdata[2]; // R5
          trigger_origin_select <= tlo_origin_t'(pwdata[5:4]); // R6
        end
        `TLO_REG_TRIG_COUNT: begin
          unlimited_count  <= pwdata[31]; // R3
          values_per_event <= (pwdata[30:14] != 17'h0 || pwdata[13:0] > `TLO_COUNT_MAX) ? `TLO_COUNT_MAX :
                              (pwdata[13:0] == 14'h0) ? 14'h1 : pwdata[13:0]; // R2
        end
        `TLO_REG_FAULT_CTRL: begin
          limit_a_compare_mode  <= tlo_cmp_t'(pwdata[1:0]);   // R8
          fsrc_a                <= tlo_fsrc_t'(pwdata[3:2]);  // R12 R13 R14
          limit_a_signal_select <= pwdata[4];                 // R15
          fault_a_drive_style   <= tlo_drive_t'(pwdata[7:6]); // R16
          limit_b_compare_mode  <= tlo_cmp_t'(pwdata[9:8]);   // R8
          fsrc_b                <= tlo_fsrc_t'(pwdata[11:10]);
          limit_b_signal_select <= pwdata[12];                // R15
          fault_b_drive_style   <= tlo_drive_t'(pwdata[15:14]); // R16
        end
        `TLO_REG_A_LOWER: a_lower <= clamp_lim(pwdata); // R9
        `TLO_REG_A_UPPER: a_upper <= clamp_lim(pwdata); // R9
        `TLO_REG_A_HYST:  limit_a_hysteresis <= clamp_hys(pwdata); // R10
        `TLO_REG_B_LOWER: b_lower <= clamp_lim(pwdata); // R9
        `TLO_REG_B_UPPER: b_upper <= clamp_lim(pwdata); // R9
        `TLO_REG_B_HYST:  limit_b_hysteresis <= clamp_hys(pwdata); // R10
        `TLO_REG_HOLD_MS: fault_min_hold <= (pwdata[31:10] != 22'h0 || pwdata[9:0] > `TLO_HOLD_MAX_MS) ?
                                            `TLO_HOLD_MAX_MS : pwdata[9:0]; // R11
        `TLO_REG_IRQ_EN:  irq_en <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Software pulse, only in software origin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sw_pulse <= 1'b0;
    else
      sw_pulse <= sw_cmd && trigger_origin_select == TLO_SRC_SW; // R7
  end

  // Trigger counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev <= 1'b0;
      remaining <= 14'h0;
      running   <= 1'b0;
    end else begin
      trig_prev <= act_lvl;
      if (trigger_origin_select == TLO_SRC_NONE) begin
        remaining <= 14'h0; // R6
        running   <= 1'b0;
      end else if (event_p && unlimited_count) begin
        running <= 1'b1; // R3
      end else if (event_p && !running) begin
        remaining <= values_per_event; // R2
      end else if (last_val) begin
        remaining <= remaining - 14'h1; // R2
      end
    end
  end

  // Gating outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acquire_en  <= 1'b0;
      emit_strobe <= 1'b0;
    end else begin
      acquire_en  <= trigger_target_select ? 1'b1 : gate;  // R1
      emit_strobe <= meas_strobe & gate;                   // R1 R19
    end
  end

  // Limit channels
  wire fault_a;
  wire fault_b;
  tlo_limit_chan #(.HOLD_CYC_PER_MS(HOLD_CYC_PER_MS)) u_chan_a (
    .pclk         (pclk),
    .presetn      (presetn),
    .cmp_mode     (limit_a_compare_mode),
    .fsrc         (fsrc_a),
    .lower        (a_lower),
    .upper        (a_upper),
    .hyst         (limit_a_hysteresis),
    .hold_ms      (fault_min_hold),
    .value        (limit_a_signal_select ? meas_sig1 : meas_sig0), // R15
    .invalid_distance_src_invalid (invalid_distance_src_invalid),
    .out_of_range (out_of_range),
    .fault        (fault_a)
  );
  tlo_limit_chan #(.HOLD_CYC_PER_MS(HOLD_CYC_PER_MS)) u_chan_b (
    .pclk         (pclk),
    .presetn      (presetn),
    .cmp_mode     (limit_b_compare_mode),
    .fsrc         (fsrc_b),
    .lower        (b_lower),
    .upper        (b_upper),
    .hyst         (limit_b_hysteresis),
    .hold_ms      (fault_min_hold),
    .value        (limit_b_signal_select ? meas_sig1 : meas_sig0), // R15
    .invalid_distance_src_invalid (invalid_distance_src_invalid),
    .out_of_range (out_of_range),
    .fault        (fault_b)
  );

  // Pin drive and interrupt events
  wire [1:0] drv_a = drive(fault_a_drive_style, fault_a); // R16
  wire [1:0] drv_b = drive(fault_b_drive_style, fault_b); // R16
  wire [3:0] ev    = {fault_b & ~fault_b_d, fault_a & ~fault_a_d, last_val & (remaining == 14'h1), event_p};
  wire       clr_w = wr_ok && paddr == `TLO_REG_IRQ_CLR;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_output_a_o  <= 1'b0;
      fault_output_a_oe <= 1'b0;
      fault_output_b_o  <= 1'b0;
      fault_output_b_oe <= 1'b0;
      fault_a_d         <= 1'b0;
      fault_b_d         <= 1'b0;
      irq_stat          <= 4'h0;
      irq               <= 1'b0;
    end else begin
      fault_output_a_o  <= drv_a[1];
      fault_output_a_oe <= drv_a[0];
      fault_output_b_o  <= drv_b[1];
      fault_output_b_oe <= drv_b[0];
      fault_a_d         <= fault_a;
      fault_b_d         <= fault_b;
      irq_stat          <= (irq_stat & ~(clr_w ? pwdata[3:0] : 4'h0)) | ev; // Set wins
      irq               <= |(((irq_stat & ~(clr_w ? pwdata[3:0] : 4'h0)) | ev) & irq_en);
    end
  end

  // Read-back mux
  wire [31:0] rd_mux =
    (paddr == `TLO_REG_TRIG_CTRL)  ? {26'h0, trigger_origin_select, 1'b0, trigger_detect_mode,
                                      trigger_polarity, trigger_target_select} :
    (paddr == `TLO_REG_TRIG_COUNT) ? {unlimited_count, 17'h0, values_per_event} :
    (paddr == `TLO_REG_FAULT_CTRL) ? {16'h0, fault_b_drive_style, 1'b0, limit_b_signal_select, fsrc_b,
                                      limit_b_compare_mode, fault_a_drive_style, 1'b0,
                                      limit_a_signal_select, fsrc_a, limit_a_compare_mode} :
    (paddr == `TLO_REG_A_LOWER)    ? a_lower :
    (paddr == `TLO_REG_A_UPPER)    ? a_upper :
    (paddr == `TLO_REG_A_HYST)     ? limit_a_hysteresis :
    (paddr == `TLO_REG_B_LOWER)    ? b_lower :
    (paddr == `TLO_REG_B_UPPER)    ? b_upper :
    (paddr == `TLO_REG_B_HYST)     ? limit_b_hysteresis :
    (paddr == `TLO_REG_HOLD_MS)    ? {22'h0, fault_min_hold} :
    (paddr == `TLO_REG_STATUS)     ? {16'h0, remaining, fault_b, fault_a} :
    (paddr == `TLO_REG_IRQ_STAT)   ? {28'h0, irq_stat} :
    (paddr == `TLO_REG_IRQ_EN)     ? {28'h0, irq_en} : 32'h0;

  // APB answer, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite & mapped) ? rd_mux : 32'h0; // R17
    end
  end

  a_sw_only_sw: assert property (@(posedge pclk) disable iff (!presetn)
    sw_pulse |-> $past(trigger_origin_select) == TLO_SRC_SW) else $error("sw pulse in wrong origin"); // R7
  a_count_load: assert property (@(posedge pclk) disable iff (!presetn)
    (event_p && !unlimited_count && !running && trigger_origin_select != TLO_SRC_NONE)
    |=> remaining == $past(values_per_event)) else $error("count not loaded"); // R2
  a_run_sticks: assert property (@(posedge pclk) disable iff (!presetn)
    (running && trigger_origin_select != TLO_SRC_NONE) |=> running) else $error("unlimited run stopped"); // R3
  a_none_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (trigger_origin_select == TLO_SRC_NONE) |=> (remaining == 14'h0 && !running)) else $error("trigger not off"); // R6
  a_free_acq: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_target_select |=> acquire_en) else $error("acquire gated in output mode"); // R1
  a_level_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (level_on && meas_strobe) |=> emit_strobe) else $error("level gate lost value"); // R19
  a_inv_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_a_drive_style == TLO_DRV_PPINV) |=> fault_output_a_o == !$past(fault_a)) else $error("inv drive"); // R16
  a_edge_once: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_sel && !trigger_detect_mode && event_p) |=> !edge_ev) else $error("edge counted twice"); // R5
endmodule // tlo_trigger_limit

// >>> verif/tlo_meas_src.sv
`timescale 1ns/10ps
// Measurement source: one value strobe every fourth cycle
module tlo_meas_src (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Value strobe
  output logic      meas_strobe
);
  logic [1:0] phase;
  // Free-running divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end
  assign meas_strobe = (phase == 2'h3);
endmodule // tlo_meas_src

// >>> verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  import tlo_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, mf_pin, sync_pin, dinv, oor;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd, v;
  logic signed [31:0] sig0, sig1;
  logic               pready, pslverr, err, acq, emit, meas, fao, faoe, fbo, fboe, irq;
  int                 n_errors, checks_done, n_emit, e0, n;
  tlo_meas_src SRC (.pclk(pclk), .presetn(presetn), .meas_strobe(meas));
  tlo_trigger_limit #(.HOLD_CYC_PER_MS(10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .multifunction_input(mf_pin), .sync_line_input(sync_pin), .meas_strobe(meas), .meas_sig0(sig0),
    .meas_sig1(sig1), .invalid_distance_src_invalid(dinv), .out_of_range(oor), .acquire_en(acq), .emit_strobe(emit),
    .fault_output_a_o(fao), .fault_output_a_oe(faoe), .fault_output_b_o(fbo), .fault_output_b_oe(fboe), .irq(irq));
  // Clock
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // Emission counter
  always @(posedge pclk) if (emit === 1'b1) n_emit++;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin n_errors++; finish_test(); end
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  function automatic logic [31:0] exp_n(input logic [31:0] c);
    return (c == 0) ? 32'h1 : c;
  endfunction
  function automatic logic [1:0] pin(input int d, input logic f);
    case (d)
      0: return {f, 1'b0};
      1: return {f, 1'b1};
      2: return {1'b1, f};
      default: return {1'b1, !f};
    endcase
  endfunction
  // One triggered burst from a chosen origin and polarity
  task automatic trig_case(input int o, input logic p, input logic [31:0] cnt);
    apb(1, 12'h000, 32'h0);
    mf_pin <= !p; sync_pin <= !p;
    cyc(8);
    apb(1, 12'h004, cnt);
    apb(1, 12'h000, {26'h0, o[1:0], 2'b00, p, 1'b1});
    e0 = n_emit;
    apb(1, 12'h008, 32'h1);
    mf_pin <= p; sync_pin <= p;
    cyc(8);
    mf_pin <= !p; sync_pin <= !p;
    cyc(80);
    chk("emits", n_emit - e0, (o == 0) ? 0 : exp_n(cnt));
  endtask
  int tv[12] = '{-50, -110, -90, -70, 50, 110, 90, 70, 0, 110, -110, 0};
  // Main sequence
  initial begin
    {psel, penable, pwrite, mf_pin, sync_pin, dinv, oor} = '0;
    paddr = '0; pwdata = '0; sig0 = 0; sig1 = 0; presetn = 0;
    n = $urandom(32'h8812);
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h02c, 0); chk("status", rd, 0);
    apb(0, 12'h03c, 0); chk("unmapped", {rd[30:0], err}, 1);
    v = $urandom_range(42940) - 21470;
    apb(1, 12'h01c, v); apb(0, 12'h01c, 0); chk("lower", rd, v);
    apb(1, 12'h020, 30000); apb(0, 12'h020, 0); chk("clamp", rd, 21470);
    v = $urandom_range(21470);
    apb(1, 12'h024, v); apb(0, 12'h024, 0); chk("hyst", rd, v);
    apb(1, 12'h004, 32'h4000); apb(0, 12'h004, 0); chk("cnt_clamp", rd, 32'd16382);
    for (int o = 0; o < 4; o++) for (int p = 0; p < 2; p++) trig_case(o, p[0], $urandom_range(5));
    apb(1, 12'h000, 32'h30); cyc(2); chk("acq_in", acq, 0);
    apb(1, 12'h000, 32'h31); cyc(2); chk("acq_out", acq, 1);
    apb(1, 12'h004, 32'h8000_0000);
    e0 = n_emit;
    apb(1, 12'h008, 32'h1);
    cyc(100);
    chk("unlimited", n_emit - e0 >= 20, 1);
    apb(1, 12'h000, 32'h0);
    cyc(4); e0 = n_emit; cyc(40);
    chk("stopped", n_emit - e0, 0);
    apb(1, 12'h000, 32'h17);
    e0 = n_emit; mf_pin <= 1; cyc(40);
    chk("level_on", n_emit - e0 >= 8, 1);
    mf_pin <= 0; cyc(8); e0 = n_emit; cyc(40);
    chk("level_off", n_emit - e0, 0);
    chk("irq_mask", irq, 0);
    apb(1, 12'h034, 32'h1); cyc(2); chk("irq_on", irq, 1);
    apb(1, 12'h038, 32'hf); apb(0, 12'h030, 0); chk("irq_clr", {rd[0], irq}, 0);
    apb(1, 12'h028, 0);
    for (int d = 0; d < 4; d++) for (int f = 0; f < 2; f++) begin
      apb(1, 12'h00c, (d << 6) | (((d << 6) | 32'h4) << 8));
      dinv <= f[0]; oor <= !f[0]; cyc(4);
      chk("fault_a", {faoe, fao}, pin(d, f[0]));
      chk("fault_b", {fboe, fbo}, pin(d, !f[0]));
    end
    dinv <= 0; oor <= 0;
    apb(1, 12'h010, -100); apb(1, 12'h014, 100); apb(1, 12'h018, 20);
    for (int i = 0; i < 12; i++) begin
      if (i % 4 == 0) apb(1, 12'h00c, 32'h88 | (i / 4));
      sig0 <= tv[i]; cyc(4);
      chk("limit", fao, (i % 4 == 1) || (i % 4 == 2));
    end
    apb(1, 12'h00c, 32'h99); apb(1, 12'h028, 2);
    sig0 <= 0; sig1 <= 110; cyc(3); sig1 <= 0; cyc(10);
    chk("held", fao, 1);
    cyc(30); chk("released", fao, 0);
    finish_test();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end
endmodule // testbench
